//--- emb_pkg.sv
package emb_pkg;
   // Hardware configuration register one bit positions that enable the bus.
   localparam int HW_CONFIG_REG_ONE_PORT_HI_BIT = 0;
   localparam int HW_CONFIG_REG_ONE_PORT_LO_BIT = 1;
   localparam logic [7:0] HW_CONFIG_REG_ONE_RESET = 8'hFF;
   localparam logic [7:0] HW_CONFIG_REG_ZERO_RESET = 8'hFF;
   // Special register address of the page register.
   localparam logic [7:0] PAGE_REG_ADDR = 8'h92;
   // Boot ROM placement.
   localparam logic [15:0] BOOT_USER_BASE = 16'hF800;
   localparam logic [15:0] BOOT_PROG_LAST = 16'h07FF;
   // Internal program memory top (last internal address).
   localparam logic [15:0] INT_PROG_LAST = 16'h7FFF;
   // Bus phase lengths in core clock cycles.
   localparam logic [1:0] ALE_CYCLES = 2'h2;
   localparam logic [1:0] STROBE_CYCLES = 2'h3;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ONES_BYTE = 8'hFF;
   typedef enum logic [1:0] {
      EMB_MODE_USER = 2'b00,
      EMB_MODE_SERIAL = 2'b01,
      EMB_MODE_PARALLEL = 2'b10,
      EMB_MODE_RESERVED = 2'b11
   } emb_mode_e;
   typedef enum logic [2:0] {
      EMB_IDLE = 3'b000,
      EMB_ADDR = 3'b001,
      EMB_SETUP = 3'b010,
      EMB_STROBE = 3'b011,
      EMB_HOLD = 3'b100
   } emb_state_e;
endpackage : emb_pkg

//--- emb_external_memory_bus.sv
// Notes on behaviour
// RULE1 - Bus active only when both enable bits zero.
// RULE2 - Every access, internal too, shown on bus.
// RULE3 - Internal accesses show zero data phase.
// RULE4 - Program reads use program strobe; data uses rd/wr.
// RULE5 - Fetch 16-bit; data 16-bit pointer or 8-bit.
// RULE6 - Page register held high for 8-bit moves.
// RULE7 - Low address and data multiplexed on low port.
// RULE8 - Bus pins driven push-pull in bus mode.
// RULE9 - Low address valid at latch strobe fall.
// RULE10 - Write data before strobe, held after it.
// RULE11 - Read data sampled just before strobe rise.
// RULE12 - Ports default I/O; untouched when disabled.
// RULE13 - Strap low forces external; else above range.
// RULE14 - Program fetch drives counter high byte.
// RULE15 - Bus enable claims P3.6/P3.7 as strobes.
// RULE16 - Config registers writable only in programming mode.
// RULE17 - Strobe straps sampled at reset select mode.
// RULE18 - Programming left only by user-mode reset; the code also leaves it on a reset sampling straps 00 (reserved mode).
// RULE19 - Boot ROM high in user, low in programming.
// RULE20 - One access at a time, latch then strobe.
`timescale 1ns/10ps
`default_nettype none
module emb_external_memory_bus
   import emb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic strap_sample,
   input wire logic external_access_strap_n,
   input wire logic program_read_strobe_n_in,
   input wire logic ale_in,
   input wire logic cfg_wr,
   input wire logic cfg_sel_one,
   input wire logic [7:0] cfg_wdata,
   input wire logic boot_rom_enable,
   input wire logic req_valid,
   input wire logic req_is_fetch,
   input wire logic req_write,
   input wire logic req_short_addr,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   input wire logic req_internal_hit,
   input wire logic [7:0] page_high_byte_reg,
   input wire logic [7:0] gpio_lo_out,
   input wire logic [7:0] gpio_hi_out,
   input wire logic gpio_p36_out,
   input wire logic gpio_p37_out,
   input wire logic [7:0] low_addr_data_port_in,
   output logic [7:0] low_addr_data_port_out,
   output logic low_addr_data_port_oe,
   output logic [7:0] high_addr_port_out,
   output logic high_addr_port_oe,
   output logic ale_out,
   output logic ale_oe,
   output logic program_read_strobe_n_out,
   output logic program_read_strobe_n_oe,
   output logic rd_n,
   output logic wr_n,
   output logic strobes_oe,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   output logic [7:0] hw_config_reg_one,
   output logic [7:0] hw_config_reg_zero,
   output logic [1:0] mode,
   output logic bus_enabled,
   output logic fetch_external,
   output logic boot_rom_hit
);
   ////////////////////////////////////////////////////////////////////////////////
   emb_state_e state;
   logic [1:0] cnt;
   logic cur_fetch;
   logic cur_write;
   logic cur_short;
   logic cur_internal;
   logic [15:0] cur_addr;
   logic [7:0] cur_wdata;
   logic force_external;
   logic flash_programming_mode;
   logic bus_on;
   logic req_external;
   logic [1:0] strap_code;

   assign bus_on = ~hw_config_reg_one[HW_CONFIG_REG_ONE_PORT_HI_BIT] & ~hw_config_reg_one[HW_CONFIG_REG_ONE_PORT_LO_BIT]; // RULE1
   assign flash_programming_mode = (mode == EMB_MODE_SERIAL) || (mode == EMB_MODE_PARALLEL);
   assign strap_code = {program_read_strobe_n_in, ale_in};
   // Fetches above internal range or any access with the strap low go outside.
   assign req_external = force_external | (req_is_fetch & (req_addr > INT_PROG_LAST)) | ~req_internal_hit; // RULE13

   ////////////////////////////////////////////////////////////////////////////////
   // Strap capture: a clocked sample at the end of any reset source.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode <= EMB_MODE_USER;
         force_external <= 1'b0;
      end else if (strap_sample) begin
         unique case (strap_code) // RULE17
            2'b01: mode <= EMB_MODE_SERIAL;
            2'b10: mode <= EMB_MODE_PARALLEL;
            2'b11: mode <= EMB_MODE_USER; // RULE18
            2'b00: mode <= EMB_MODE_RESERVED;
         endcase
         force_external <= ~external_access_strap_n; // RULE13
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers default to I/O ports and change only while programming.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hw_config_reg_one <= HW_CONFIG_REG_ONE_RESET; // RULE12
      end else if (cfg_wr && flash_programming_mode && cfg_sel_one) begin // RULE16
         hw_config_reg_one <= cfg_wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hw_config_reg_zero <= HW_CONFIG_REG_ZERO_RESET;
      end else if (cfg_wr && flash_programming_mode && !cfg_sel_one) begin // RULE16
         hw_config_reg_zero <= cfg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status decodes of the current request, one cycle late.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_enabled <= 1'b0;
      end else begin
         bus_enabled <= bus_on; // RULE1
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fetch_external <= 1'b0;
      end else begin
         fetch_external <= req_valid & req_is_fetch & req_external & (bus_on | force_external); // RULE13
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         boot_rom_hit <= 1'b0;
      end else if (flash_programming_mode) begin
         boot_rom_hit <= req_valid & req_is_fetch & (req_addr <= BOOT_PROG_LAST); // RULE19
      end else begin
         boot_rom_hit <= req_valid & req_is_fetch & boot_rom_enable & (req_addr >= BOOT_USER_BASE); // RULE19
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access fields are captured once, when a request is taken.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_fetch <= 1'b0;
         cur_write <= 1'b0;
         cur_short <= 1'b0;
         cur_internal <= 1'b0;
         cur_addr <= 16'h0000;
         cur_wdata <= ZERO_BYTE;
      end else if (state == EMB_IDLE && req_valid && bus_on) begin
         cur_fetch <= req_is_fetch;
         cur_write <= req_write & ~req_is_fetch;
         cur_short <= req_short_addr & ~req_is_fetch; // RULE5
         cur_internal <= ~req_external;
         cur_addr <= req_addr;
         cur_wdata <= req_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access sequencer: address phase with latch pulse, then one strobe.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= EMB_IDLE;
         cnt <= 2'h0;
      end else begin
         unique case (state)
            EMB_IDLE: begin
               if (req_valid && bus_on) begin // RULE2 RULE20
                  state <= EMB_ADDR;
                  cnt <= ALE_CYCLES - 2'h1;
               end
            end
            EMB_ADDR: begin
               if (cnt == 2'h0) begin
                  state <= EMB_SETUP;
               end else begin
                  cnt <= cnt - 2'h1;
               end
            end
            EMB_SETUP: begin
               state <= EMB_STROBE;
               cnt <= STROBE_CYCLES - 2'h1;
            end
            EMB_STROBE: begin
               if (cnt == 2'h0) begin
                  state <= EMB_HOLD;
               end else begin
                  cnt <= cnt - 2'h1;
               end
            end
            EMB_HOLD: begin
               state <= EMB_IDLE;
            end
            default: begin
               state <= EMB_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // High port: page register on short moves, else the address high byte.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         high_addr_port_out <= ONES_BYTE;
         high_addr_port_oe <= 1'b0;
      end else if (!bus_on) begin
         high_addr_port_out <= gpio_hi_out; // RULE12
         high_addr_port_oe <= 1'b0;
      end else begin
         high_addr_port_out <= cur_short ? page_high_byte_reg : cur_addr[15:8]; // RULE6 RULE14
         high_addr_port_oe <= 1'b1; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Low port: address in the latch phase, then data, or zeros for internal hits.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         low_addr_data_port_out <= ONES_BYTE;
         low_addr_data_port_oe <= 1'b0;
      end else if (!bus_on) begin
         low_addr_data_port_out <= gpio_lo_out; // RULE12
         low_addr_data_port_oe <= 1'b0;
      end else begin
         unique case (state)
            EMB_ADDR: begin
               low_addr_data_port_out <= cur_addr[7:0]; // RULE7 RULE9
               low_addr_data_port_oe <= 1'b1;
            end
            EMB_SETUP, EMB_STROBE, EMB_HOLD: begin
               low_addr_data_port_out <= cur_internal ? ZERO_BYTE : cur_wdata; // RULE3 RULE10
               low_addr_data_port_oe <= cur_internal | cur_write; // RULE8
            end
            default: begin
               low_addr_data_port_out <= req_addr[7:0];
               low_addr_data_port_oe <= req_valid;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address latch strobe: one pulse per access, falling before the strobe phase.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ale_out <= 1'b0;
         ale_oe <= 1'b0;
      end else if (!bus_on) begin
         ale_out <= 1'b0;
         ale_oe <= 1'b0;
      end else begin
         ale_out <= (state == EMB_IDLE && req_valid) || (state == EMB_ADDR && cnt != 2'h0); // RULE20
         ale_oe <= 1'b1; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program read strobe for fetches; it rises on the same clock edge that samples the data.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         program_read_strobe_n_out <= 1'b1;
         program_read_strobe_n_oe <= 1'b0;
      end else if (!bus_on) begin
         program_read_strobe_n_out <= 1'b1;
         program_read_strobe_n_oe <= 1'b0;
      end else begin
         program_read_strobe_n_out <= ~(cur_fetch && state == EMB_SETUP) &
                                      ~(cur_fetch && state == EMB_STROBE && cnt != 2'h0); // RULE4
         program_read_strobe_n_oe <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data read strobe on the P3.7 pin; general I/O value while the bus is off.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_n <= 1'b1;
      end else if (!bus_on) begin
         rd_n <= gpio_p37_out;
      end else begin
         rd_n <= ~(!cur_fetch && !cur_write && state == EMB_SETUP) &
                 ~(!cur_fetch && !cur_write && state == EMB_STROBE && cnt != 2'h0); // RULE4
      end
   end

   // Data write strobe on the P3.6 pin; the data phase spans it on both sides.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_n <= 1'b1;
      end else if (!bus_on) begin
         wr_n <= gpio_p36_out;
      end else begin
         wr_n <= ~(cur_write && state == EMB_STROBE); // RULE10
      end
   end

   // The strobe pins are claimed for the bus whenever it is enabled.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strobes_oe <= 1'b0;
      end else begin
         strobes_oe <= bus_on; // RULE15
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Answer pulse in the cycle after the hold phase.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= (state == EMB_HOLD);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= bus_on && (state == EMB_IDLE) && !req_valid;
      end
   end

   // Read data taken on the last strobe cycle, before the strobe rises.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp_rdata <= ZERO_BYTE;
      end else if (state == EMB_STROBE && cnt == 2'h0 && !cur_write) begin
         rsp_rdata <= low_addr_data_port_in; // RULE11
      end
   end
endmodule : emb_external_memory_bus
`default_nettype wire

//--- emb_bus_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module emb_chk
   import emb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic strap_sample,
   input wire logic program_read_strobe_n_in,
   input wire logic ale_in,
   input wire logic cfg_wr,
   input wire logic [7:0] low_addr_data_port_out,
   input wire logic low_addr_data_port_oe,
   input wire logic high_addr_port_oe,
   input wire logic ale_out,
   input wire logic program_read_strobe_n_out,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic strobes_oe,
   input wire logic rsp_valid,
   input wire logic [7:0] hw_config_reg_one,
   input wire logic [1:0] mode
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic off;
   assign off = hw_config_reg_one[1:0] != 2'h0;
   sequence s_strb_fall; strobes_oe && ($fell(rd_n) || $fell(wr_n) || $fell(program_read_strobe_n_out)); endsequence
   sequence s_wr_end; !wr_n ##1 wr_n; endsequence
   property p_off; off && $past(off) |-> !low_addr_data_port_oe && !high_addr_port_oe && !strobes_oe; endproperty
   a_off: assert property (p_off) else $error("bus pins driven while off");
   property p_no_rsp; off && $past(off) |-> !rsp_valid; endproperty
   a_no_rsp: assert property (p_no_rsp) else $error("answer while off");
   property p_ale; $fell(ale_out) |-> low_addr_data_port_oe && $stable(low_addr_data_port_out); endproperty
   a_ale: assert property (p_ale) else $error("address moved at latch fall");
   property p_latch; s_strb_fall |-> !ale_out && ($past(ale_out, 2) || $past(ale_out, 3)); endproperty
   a_latch: assert property (p_latch) else $error("strobe without latch pulse");
   property p_wr; !wr_n |-> low_addr_data_port_oe && $stable(low_addr_data_port_out); endproperty
   a_wr: assert property (p_wr) else $error("write data not set up");
   property p_wr_hold; s_wr_end |-> low_addr_data_port_oe && $stable(low_addr_data_port_out); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data not held");
   property p_excl; !(!wr_n && (!rd_n || !program_read_strobe_n_out)); endproperty
   a_excl: assert property (p_excl) else $error("two strobes at once");
   property p_mode; strap_sample |=> mode == ~$past({ale_in, program_read_strobe_n_in}); endproperty
   a_mode: assert property (p_mode) else $error("wrong mode from straps");
   property p_cfg; cfg_wr && mode == EMB_MODE_USER |=> $stable(hw_config_reg_one); endproperty
   a_cfg: assert property (p_cfg) else $error("config written in user mode");
endmodule : emb_chk
bind emb_external_memory_bus emb_chk u_chk (.ref_clk, .rst, .strap_sample, .program_read_strobe_n_in, .ale_in,
   .cfg_wr, .low_addr_data_port_out, .low_addr_data_port_oe, .high_addr_port_oe, .ale_out,
   .program_read_strobe_n_out, .rd_n, .wr_n, .strobes_oe, .rsp_valid, .hw_config_reg_one, .mode);
`default_nettype wire

//--- emb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module emb_mem_model (
   input wire logic ref_clk,
   input wire logic [7:0] lo_out,
   input wire logic lo_oe,
   input wire logic [7:0] hi_out,
   input wire logic ale,
   input wire logic program_read_strobe_n_n,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [7:0] pin
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat = 8'h00;
   logic [7:0] junk = 8'h5A;
   initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
   always @(negedge ale) lat <= lo_out;
   always @(posedge wr_n) mem[{hi_out, lat}] <= lo_out;
   // A released bus shows a pattern that moves every cycle.
   always @(posedge ref_clk) junk <= {junk[6:0], ~junk[7]};
   assign pin = lo_oe ? lo_out : (!rd_n || !program_read_strobe_n_n) ? mem[{hi_out, lat}] : junk;
endmodule : emb_mem_model
`default_nettype wire

//--- external_memory_bus_tb.sv
`timescale 1ns/10ps
`default_nettype none
module external_memory_bus_tb
   import emb_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic strap_sample, external_access_strap_n, program_read_strobe_n_in, ale_in, cfg_wr, cfg_sel_one;
   logic boot_rom_enable, req_valid, req_is_fetch, req_write, req_short_addr, req_internal_hit, gpio_p36_out;
   logic gpio_p37_out, low_addr_data_port_oe, high_addr_port_oe, ale_out, ale_oe, program_read_strobe_n_out;
   logic program_read_strobe_n_oe, rd_n, wr_n, strobes_oe, req_ready, rsp_valid, bus_enabled, fetch_external;
   logic boot_rom_hit, ale_q, strb;
   logic [7:0] cfg_wdata, req_wdata, page_high_byte_reg, gpio_lo_out, gpio_hi_out, low_addr_data_port_in;
   logic [7:0] low_addr_data_port_out, high_addr_port_out, rsp_rdata, hw_config_reg_one, hw_config_reg_zero;
   logic [7:0] exp_mem [0:65535];
   logic [15:0] req_addr, exp_a, ra;
   logic [1:0] mode;
   int errors = 0;
   int cmp_count = 0;
   emb_external_memory_bus u_dut (.*);
   emb_mem_model u_mem (.ref_clk, .lo_out(low_addr_data_port_out), .lo_oe(low_addr_data_port_oe),
      .hi_out(high_addr_port_out), .ale(ale_out), .program_read_strobe_n_n(program_read_strobe_n_out), .rd_n, .wr_n,
      .pin(low_addr_data_port_in));
   always #10 ref_clk = ~ref_clk;
   task automatic chk(string what, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, e, s);
      end
   endtask : chk
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task automatic do_reset(logic p, logic a);
      rst = 1'b1;
      {program_read_strobe_n_in, ale_in} = {p, a};
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      strap_sample = 1'b1;
      @(negedge ref_clk);
      strap_sample = 1'b0;
      chk("mode", {~a, ~p}, mode);
   endtask : do_reset
   task automatic cfg(logic one, logic [7:0] v);
      {cfg_sel_one, cfg_wdata, cfg_wr} = {one, v, 1'b1};
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      @(negedge ref_clk);
   endtask : cfg
   task automatic acc(logic f, logic w, logic s, logic ih, logic [15:0] a, logic en);
      int n;
      logic pm;
      n = 0;
      pm = (mode == EMB_MODE_SERIAL) || (mode == EMB_MODE_PARALLEL);
      exp_a = s ? {page_high_byte_reg, a[7:0]} : a;
      {req_is_fetch, req_write, req_short_addr, req_internal_hit, req_addr} = {f, w, s, ih, a};
      req_wdata = 8'($urandom);
      req_valid = 1'b1;
      @(negedge ref_clk);
      if (f) chk("fext", en && a > INT_PROG_LAST, fetch_external);
      chk("busen", en, bus_enabled);
      if (f) chk("boot", pm ? a <= BOOT_PROG_LAST : boot_rom_enable && a >= BOOT_USER_BASE, boot_rom_hit);
      while (rsp_valid !== 1'b1 && n < 12) begin
         @(negedge ref_clk);
         n++;
      end
      req_valid = 1'b0;
      if (!en) chk("gpio", {8'h00, gpio_hi_out}, {7'h00, rsp_valid, high_addr_port_out});
      else if (n == 12) begin
         errors++;
         stop_test();
      end
      else if (w) exp_mem[exp_a] = req_wdata;
      else if (!ih) chk("rdata", exp_mem[exp_a], rsp_rdata);
      @(negedge ref_clk);
      chk("ready", en, req_ready);
   endtask : acc
   always @(negedge ref_clk) begin
      strb = strobes_oe && (!program_read_strobe_n_out || !rd_n || !wr_n);
      if (strb) chk("oe", 3'h7, {high_addr_port_oe, ale_oe, program_read_strobe_n_oe});
      if (!rst && (strb || (ale_q && !ale_out))) chk("high", exp_a[15:8], high_addr_port_out);
      if (!rst && ale_q && !ale_out) chk("low", exp_a[7:0], low_addr_data_port_out);
      if (strb) chk("strb", req_is_fetch ? 3'h3 : req_write ? 3'h6 : 3'h5, {program_read_strobe_n_out, rd_n, wr_n});
      if (strb && req_internal_hit && low_addr_data_port_oe) chk("zero", 16'h0000, low_addr_data_port_out);
      ale_q = ale_out;
   end
   initial begin
      {strap_sample, cfg_wr, cfg_sel_one, req_valid, req_is_fetch, req_write, req_short_addr} = 7'h00;
      {req_internal_hit, gpio_p36_out, gpio_p37_out, external_access_strap_n, boot_rom_enable} = 5'h0B;
      {cfg_wdata, req_wdata, req_addr, page_high_byte_reg, gpio_lo_out, gpio_hi_out} = 56'h00A5_0000_005A_C3;
      {program_read_strobe_n_in, ale_in, exp_a} = 18'h30000;
      for (int i = 0; i < 65536; i++) exp_mem[i] = 8'(i ^ (i >> 8));
      void'($urandom(41220));
      for (int k = 3; k < 7; k++) begin
         do_reset(k[1], k[0]);
         cfg(1'b1, 8'hFC);
         cfg(1'b0, 8'h3C);
         chk("cfgregs", k > 4 ? 16'hFC3C : 16'hFFFF, {hw_config_reg_one, hw_config_reg_zero});
         if (k == 3) acc(1'b1, 1'b0, 1'b0, 1'b0, 16'hF900, 1'b0);
      end
      repeat (8) begin
         ra = 16'($urandom);
         page_high_byte_reg = 8'($urandom);
         boot_rom_enable = 1'($urandom);
         acc(1'b0, 1'b1, ra[0], 1'b0, ra, 1'b1);
         acc(1'b0, 1'b0, ra[0], 1'b0, ra, 1'b1);
         acc(1'b1, 1'b0, 1'b0, 1'b0, ra | 16'h8000, 1'b1);
         acc(1'b1, 1'b0, 1'b0, 1'b1, ra & 16'h0FFF, 1'b1);
      end
      do_reset(1'b1, 1'b1);
      chk("cfgregs", 16'hFFFF, {hw_config_reg_one, hw_config_reg_zero});
      stop_test();
   end
endmodule : external_memory_bus_tb
`default_nettype wire
